// *** hdl/sram_ctl.sv ***
// Host-side controller driving a 16K x 1 asynchronous static memory
`timescale 1ns/10ps
`include "sram_ctl_defines.svh"
// How it works
// [RL1] Word select is 14 bits wide, so the host reaches 16384 one-bit words.
// [RL2] The memory has no clock, so every access is sequenced by pin levels.
// [RL3] Write strobe stays high through every read and data in is not used.
// [RL4] Select-controlled reads set the word select before select falls.
// [RL5] Address-controlled reads keep select steady while the address moves.
// [RL6] Late writes raise the write strobe first, address steady meanwhile.
// [RL7] Early writes raise select before the write strobe.
// [RL8] Early writes lower the strobe ahead of select, so output stays off.
// [RL9] Select high is standby and the memory output is then undriven.
// [RL10] During retention select is held high and nothing is started.
// [RL11] After retention the host waits over 55 ns before any access.
// [RL12] The data bit held when the first strobe rises is what is stored.
// [RL13] Read data is sampled only while select is low and strobe high.
module sram_ctl
  import sram_ctl_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W
) (
  input  wire logic              CLK,
  input  wire logic              RSTN,
  input  wire logic              REQ_VALID,
  output logic                   REQ_READY,
  input  wire sram_ctl_pkg::op_t REQ_OP,
  input  wire logic [ADDR_W-1:0] REQ_ADDR,
  input  wire logic              REQ_DATA,
  input  wire logic              REQ_HOLD_SEL,
  output logic                   RSP_VALID,
  output logic                   RSP_DATA,
  input  wire logic              RETAIN_REQ,
  output logic                   RETAIN_ACTIVE,
  output logic [ADDR_W-1:0]      MEM_WORD_SELECT,
  output logic                   MEM_SEL_N,
  output logic                   MEM_WR_N,
  output logic                   MEM_DIN,
  input  wire logic              MEM_DOUT
);
  import sram_ctl_pkg::*;

  localparam logic [`CNT_W-1:0] STROBE_N = `CNT_W'(`STROBE_CYC);
  localparam logic [`CNT_W-1:0] ACCESS_N = `CNT_W'(`ACCESS_CYC);
  localparam logic [`CNT_W-1:0] RETURN_N = `CNT_W'(`RETURN_CYC);
  localparam logic [`CNT_W-1:0] SETTLE_N = `CNT_W'(`SETTLE_CYC);

  // Sequencer state and the registered pin copies
  state_t            st_r, st_nxt;
  op_t               op_r, op_nxt;
  logic [`CNT_W-1:0] cnt_r, cnt_nxt;
  logic              keep_r, keep_nxt;
  logic              rsp_v_r, rsp_v_nxt;
  logic              rsp_d_r, rsp_d_nxt;
  logic [13:0]       addr_q;
  logic              sel_q;
  logic              wr_q;
  logic              din_q;

  pin_drv_if pins ();

  // Registered pins keep strobes glitch-free toward the memory
  pin_reg u_pins (
    .clk     (CLK),
    .rst_n   (RSTN),
    .nxt     (pins),
    .addr_r  (addr_q),
    .sel_n_r (sel_q),
    .wr_n_r  (wr_q),
    .din_r   (din_q)
  );

  // Pins and answer come straight from flip-flops
  assign MEM_WORD_SELECT = addr_q[ADDR_W-1:0]; // RL1
  assign MEM_SEL_N       = sel_q;
  assign MEM_WR_N        = wr_q;
  assign MEM_DIN         = din_q;
  assign RSP_VALID       = rsp_v_r;
  assign RSP_DATA        = rsp_d_r;
  assign RETAIN_ACTIVE   = (st_r == ST_RETAIN);
  // A write behind a held select waits one clock for select to rise
  assign REQ_READY       = (st_r == ST_IDLE) && !RETAIN_REQ &&
                           !(keep_r && (REQ_OP != OP_READ));

  // Sequencer: all pin edges are spaced in whole clocks
  always_comb begin
    st_nxt     = st_r;
    op_nxt     = op_r;
    cnt_nxt    = cnt_r;
    keep_nxt   = keep_r;
    pins.addr  = addr_q;
    pins.sel_n = sel_q;
    pins.wr_n  = wr_q;
    pins.din   = din_q;
    unique case (st_r)
      ST_IDLE: begin
        // Select stays low here only behind an address-controlled read
        pins.wr_n = 1'b1; // RL3
        if (!keep_r)
          pins.sel_n = 1'b1; // RL9
        if (RETAIN_REQ) begin
          pins.sel_n = 1'b1; // RL10
          keep_nxt   = 1'b0;
          st_nxt     = ST_RETAIN;
        end else if (REQ_VALID && keep_r && (REQ_OP != OP_READ)) begin
          // Raise the held select a clock ahead of a write, so the word
          // select never moves while select and write strobe are both low
          pins.sel_n = 1'b1; // RL6
          keep_nxt   = 1'b0;
        end else if (REQ_VALID) begin
          op_nxt    = REQ_OP;
          pins.addr = 14'(REQ_ADDR); // RL4
          pins.din  = REQ_DATA;
          cnt_nxt   = SETTLE_N;
          keep_nxt  = (REQ_OP == OP_READ) && REQ_HOLD_SEL;
          // Early write drops strobe before select
          if (REQ_OP == OP_EARLY_WR)
            pins.wr_n = 1'b0; // RL8
          st_nxt = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Address settled a full clock before select falls
        cnt_nxt = cnt_r - `CNT_W'(1);
        if (cnt_r <= `CNT_W'(1)) begin
          pins.sel_n = 1'b0; // RL4
          if (op_r == OP_LATE_WR)
            pins.wr_n = 1'b0; // RL6
          cnt_nxt = (op_r == OP_READ) ? ACCESS_N : STROBE_N;
          st_nxt  = ST_STROBE;
        end
      end
      ST_STROBE: begin
        // Address never moves during the strobe state, where select is low
        cnt_nxt = cnt_r - `CNT_W'(1);
        if (cnt_r <= `CNT_W'(1)) begin
          unique case (op_r)
            OP_READ: begin
              if (!keep_r)
                pins.sel_n = 1'b1; // RL5
              st_nxt = keep_r ? ST_IDLE : ST_HOLD;
            end
            OP_LATE_WR: begin
              pins.wr_n = 1'b1; // RL6 RL12
              st_nxt    = ST_RELEASE;
            end
            OP_EARLY_WR: begin
              pins.sel_n = 1'b1; // RL7 RL12
              st_nxt     = ST_RELEASE;
            end
            default: st_nxt = ST_HOLD;
          endcase
        end
      end
      ST_RELEASE: begin
        // Second strobe rises one clock after the first
        pins.sel_n = 1'b1;
        pins.wr_n  = 1'b1;
        st_nxt     = ST_HOLD;
      end
      ST_HOLD: begin
        // One idle clock covers output turn-off time
        st_nxt = ST_IDLE;
      end
      ST_RETAIN: begin
        // Select held high until the retention request drops
        pins.sel_n = 1'b1; // RL10
        pins.wr_n  = 1'b1;
        if (!RETAIN_REQ) begin
          cnt_nxt = RETURN_N;
          st_nxt  = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Wait counts from release of retention request
        cnt_nxt = cnt_r - `CNT_W'(1);
        if (cnt_r <= `CNT_W'(1))
          st_nxt = ST_IDLE; // RL11
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Read answer: valid for one clock, data kept until the next read
  always_comb begin
    rsp_v_nxt = 1'b0;
    rsp_d_nxt = rsp_d_r;
    // Sampled on the last access clock, select low and strobe high
    if ((st_r == ST_STROBE) && (op_r == OP_READ) &&
        (cnt_r <= `CNT_W'(1))) begin
      rsp_v_nxt = 1'b1;
      rsp_d_nxt = MEM_DOUT; // RL13
    end
  end

  // Sequencer state registers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_r    <= ST_IDLE;
      op_r    <= OP_READ;
      cnt_r   <= '0;
      keep_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      op_r    <= op_nxt;
      cnt_r   <= cnt_nxt;
      keep_r  <= keep_nxt;
    end
  end

  // Answer registers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      rsp_v_r <= 1'b0;
      rsp_d_r <= 1'b0;
    end else begin
      rsp_v_r <= rsp_v_nxt;
      rsp_d_r <= rsp_d_nxt;
    end
  end
endmodule

// *** hdl/sram_ctl_defines.svh ***
// Timing counts and widths for the 16K x 1 static memory controller
`ifndef SRAM_CTL_DEFINES_SVH
`define SRAM_CTL_DEFINES_SVH
`define CLK_PERIOD_NS      25
`define ADDR_W             14
`define MEM_WORDS          16384
`define TWLWH_NS           45
`define TDVWH_NS           35
`define TAVQV_NS           85
`define TWLQZ_NS           30
`define TEHQZ_NS           30
`define TRETURN_NS         55
`define SETTLE_NS          15
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC  (`CYC_MIN(`TWLWH_NS))
`define ACCESS_CYC  (`CYC_MIN(`TAVQV_NS) + 1)
`define RETURN_CYC  (`CYC_MIN(`TRETURN_NS) + 1)
`define SETTLE_CYC  (`CYC_MIN(`SETTLE_NS))
`define CNT_W              4
`endif

// *** hdl/sram_ctl_pkg.sv ***
// Types shared by the memory controller modules
package sram_ctl_pkg;
  typedef enum logic [1:0] {OP_READ, OP_LATE_WR, OP_EARLY_WR} op_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_STROBE, ST_RELEASE, ST_HOLD, ST_RETAIN, ST_WAKE
  } state_t;
endpackage

// *** hdl/pin_drv_if.sv ***
// Pin bundle between sequencer and pin register stage
`timescale 1ns/10ps
interface pin_drv_if;
  logic [13:0] addr;
  logic        sel_n;
  logic        wr_n;
  logic        din;
  modport src (output addr, sel_n, wr_n, din);
  modport dst (input  addr, sel_n, wr_n, din);
endinterface

// *** hdl/pin_reg.sv ***
// Output flip-flops that drive the memory pins
`timescale 1ns/10ps
module pin_reg (
  input  wire logic        clk,
  input  wire logic        rst_n,
  pin_drv_if.dst           nxt,
  output logic [13:0]      addr_r,
  output logic             sel_n_r,
  output logic             wr_n_r,
  output logic             din_r
);
  // Pins idle deselected and read-safe out of reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      addr_r  <= 14'h0000;
      sel_n_r <= 1'b1;
      wr_n_r  <= 1'b1;
      din_r   <= 1'b0;
    end else begin
      addr_r  <= nxt.addr;
      sel_n_r <= nxt.sel_n;
      wr_n_r  <= nxt.wr_n;
      din_r   <= nxt.din;
    end
  end
endmodule

// *** test/sram_mem_model.sv ***
// Behavioural 16K x 1 static memory seen by the controller
`timescale 1ns/10ps
module sram_mem_model (
  input  wire logic [13:0] word_select,
  input  wire logic        sel_n,
  input  wire logic        wr_n,
  input  wire logic        din,
  output logic             dout
);
  logic mem [0:16383];
  logic last_q = 1'b0;
  // No clock: levels alone write, later value wins until a strobe rises
  always @* begin
    if (!sel_n && !wr_n)
      mem[word_select] = din;
  end
  // Undriven output shows the inverse of the last bit, not a stale copy
  always @* begin
    if (!sel_n && wr_n)
      last_q = mem[word_select];
  end
  assign dout = (!sel_n && wr_n) ? mem[word_select] : ~last_q;
endmodule

// *** test/sram_ctl_checker.sv ***
// Pin sequencing checker for the memory controller
`timescale 1ns/10ps
module sram_ctl_checker
  import sram_ctl_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RSTN,
  input wire logic              REQ_VALID,
  input wire logic              REQ_READY,
  input wire sram_ctl_pkg::op_t REQ_OP,
  input wire logic              REQ_HOLD_SEL,
  input wire logic              RSP_VALID,
  input wire logic              RETAIN_REQ,
  input wire logic              RETAIN_ACTIVE,
  input wire logic [13:0]       MEM_WORD_SELECT,
  input wire logic              MEM_SEL_N,
  input wire logic              MEM_WR_N
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // Accepted request
  wire take = REQ_VALID && REQ_READY;
  property p_rd_wr; take && REQ_OP == OP_READ |=> MEM_WR_N [*6]; endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("strobe low in read");
  property p_sel; $fell(MEM_SEL_N) |-> $stable(MEM_WORD_SELECT); endproperty
  a_sel: assert property (p_sel) else $error("address moved at select");
  property p_hold;
    take && REQ_OP == OP_READ && REQ_HOLD_SEL |-> ##2 !MEM_SEL_N [*5];
  endproperty
  a_hold: assert property (p_hold) else $error("select not held");
  property p_late;
    take && REQ_OP == OP_LATE_WR |-> ##2 (!MEM_SEL_N && !MEM_WR_N) ##1
      (!MEM_SEL_N && !MEM_WR_N && $stable(MEM_WORD_SELECT)) ##1
      (MEM_WR_N && !MEM_SEL_N) ##1 MEM_SEL_N;
  endproperty
  a_late: assert property (p_late) else $error("late write order");
  property p_early;
    take && REQ_OP == OP_EARLY_WR |-> ##2 (!MEM_WR_N && !MEM_SEL_N) ##2
      (MEM_SEL_N && !MEM_WR_N) ##1 MEM_WR_N;
  endproperty
  a_early: assert property (p_early) else $error("early write order");
  property p_ret; RETAIN_ACTIVE |-> MEM_SEL_N && !REQ_READY; endproperty
  a_ret: assert property (p_ret) else $error("select low in retention");
  property p_wake; $fell(RETAIN_REQ) |-> MEM_SEL_N [*3]; endproperty
  a_wake: assert property (p_wake) else $error("access too soon");
  property p_rsp; take && REQ_OP == OP_READ |-> ##7 RSP_VALID; endproperty
  a_rsp: assert property (p_rsp) else $error("read answer late");
endmodule
bind sram_ctl sram_ctl_checker chk_i (.CLK(CLK), .RSTN(RSTN),
  .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .REQ_OP(REQ_OP),
  .REQ_HOLD_SEL(REQ_HOLD_SEL), .RSP_VALID(RSP_VALID),
  .RETAIN_REQ(RETAIN_REQ), .RETAIN_ACTIVE(RETAIN_ACTIVE),
  .MEM_WORD_SELECT(MEM_WORD_SELECT), .MEM_SEL_N(MEM_SEL_N),
  .MEM_WR_N(MEM_WR_N));

// *** test/async_sram_16k_by_1_bench.sv ***
// Self-checking bench for the memory controller
`timescale 1ns/10ps
`include "sram_ctl_defines.svh"
module async_sram_16k_by_1_bench;
  import sram_ctl_pkg::*;
  logic CLK = 0, RSTN = 0, rv = 0, hs = 0, rr = 0, rd = 0;
  op_t         op = OP_READ;
  logic [13:0] ad = 14'h0, ws;
  logic        ready, rspv, rsp, ret, seln, wrn, din, dout;
  int          bad_count = 0, n_compared = 0;
  always #12.5 CLK = ~CLK;
  sram_ctl dut (.CLK(CLK), .RSTN(RSTN), .REQ_VALID(rv), .REQ_READY(ready),
    .REQ_OP(op), .REQ_ADDR(ad), .REQ_DATA(rd), .REQ_HOLD_SEL(hs),
    .RSP_VALID(rspv), .RSP_DATA(rsp), .RETAIN_REQ(rr),
    .RETAIN_ACTIVE(ret), .MEM_WORD_SELECT(ws), .MEM_SEL_N(seln),
    .MEM_WR_N(wrn), .MEM_DIN(din), .MEM_DOUT(dout));
  sram_mem_model mem (.word_select(ws), .sel_n(seln), .wr_n(wrn),
    .din(din), .dout(dout));
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task chk(logic [13:0] g, logic [13:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // One request, held until the edge that takes it
  task issue(op_t o, logic [13:0] a, logic d, logic h);
    int i;
    op = o;
    ad = a;
    rd = d;
    hs = h;
    rv = 1;
    i = 0;
    #1;
    while (!ready && i < 20) begin
      @(negedge CLK);
      #1;
      i++;
    end
    if (i == 20) begin
      bad_count++;
      close_out;
    end
    @(negedge CLK);
    rv = 0;
  endtask
  // Read with junk on the data input; answer after settle and access
  task rd_chk(logic [13:0] a, logic e, logic h);
    int i;
    issue(OP_READ, a, ~e, h);
    i = 0;
    while (!rspv && i < 20) begin
      @(negedge CLK);
      i++;
    end
    chk(14'(i), 14'(`SETTLE_CYC + `ACCESS_CYC));
    chk({13'h0, rsp}, {13'h0, e});
  endtask
  task t_writes;
    issue(OP_LATE_WR, 14'h3fff, 1'b1, 1'b0);
    issue(OP_EARLY_WR, 14'h0000, 1'b1, 1'b0);
    issue(OP_EARLY_WR, 14'h3fff, 1'b0, 1'b0);
    issue(OP_LATE_WR, 14'h0001, 1'b0, 1'b0);
    rd_chk(14'h3fff, 1'b0, 1'b0);
    rd_chk(14'h0000, 1'b1, 1'b0);
  endtask
  // Address-controlled reads with select left low, then a write behind one
  task t_hold;
    rd_chk(14'h0000, 1'b1, 1'b1);
    rd_chk(14'h0001, 1'b0, 1'b1);
    rd_chk(14'h0000, 1'b1, 1'b0);
    rd_chk(14'h0001, 1'b0, 1'b1);
    issue(OP_EARLY_WR, 14'h0002, 1'b1, 1'b0);
    rd_chk(14'h0002, 1'b1, 1'b0);
  endtask
  task t_retain;
    rr = 1;
    repeat (3) @(negedge CLK);
    chk({11'h0, ret, seln, ready}, 14'h6);
    rr = 0;
    rd_chk(14'h0000, 1'b1, 1'b0);
  endtask
  initial begin
    repeat (2) @(negedge CLK);
    chk({11'h0, seln, wrn, rspv}, 14'h6);
    RSTN = 1;
    t_writes;
    t_hold;
    t_retain;
    close_out;
  end
endmodule
